// ### hdl/power_wake_pkg.sv
// Package for the power-mode sequencer and low-leakage wake unit
package power_wake_pkg;

    localparam int PIN_COUNT    = 32;
    localparam int MODULE_COUNT = 8;

    // Pins that really reach a pad; the rest are reserved
    localparam logic [31:0] PIN_PRESENT_MASK = 32'h1BC7_FFFF;
    localparam int PIN_USB_DP = 27;
    localparam int PIN_USB_DM = 28;
    // Module inputs in use: 0 timer, 1 comparator, 4 touch, 5 alarm, 7 seconds
    localparam logic [7:0] MODULE_PRESENT_MASK = 8'hB3;

    // Register indices on the plain register port
    localparam logic [3:0] REG_MODE_CTRL   = 4'h0;
    localparam logic [3:0] REG_MODE_STAT   = 4'h1;
    localparam logic [3:0] REG_PIN_ENABLE  = 4'h2;
    localparam logic [3:0] REG_MOD_ENABLE  = 4'h3;
    localparam logic [3:0] REG_PIN_FLAGS   = 4'h4;
    localparam logic [3:0] REG_WAKE_ACK    = 4'h5;
    localparam logic [3:0] REG_IRQ_STATUS  = 4'h6;
    localparam logic [3:0] REG_IRQ_ENABLE  = 4'h7;
    localparam logic [3:0] REG_IRQ_CLEAR   = 4'h8;
    localparam logic [3:0] REG_MOD_FLAGS   = 4'h9;

    // Mode control field positions
    localparam int CTRL_RUN_LSB   = 0;
    localparam int CTRL_STOP_LSB  = 2;
    localparam int CTRL_POR_BIT   = 5;

    // Reset values
    localparam logic [31:0] PIN_ENABLE_RESET = 32'h0000_0000;
    localparam logic [7:0]  MOD_ENABLE_RESET = 8'h00;
    localparam logic [5:0]  MODE_CTRL_RESET  = 6'h00;

    // Interrupt status bits
    localparam int IRQ_WAKE_BIT  = 0;
    localparam int IRQ_ENTER_BIT = 1;

    typedef enum logic [1:0] {
        RUN_NORMAL,
        RUN_HIGH_SPEED,
        RUN_VERY_LOW_POWER
    } run_cfg_t;

    typedef enum logic [2:0] {
        STOP_NORMAL,
        STOP_VERY_LOW_POWER,
        STOP_LOW_LEAK,
        STOP_UPPER_LEVEL,
        STOP_MIDDLE_LEVEL,
        STOP_DEEPEST_LEVEL
    } stop_cfg_t;

    typedef enum logic [3:0] {
        PM_RUN,
        PM_HIGH_SPEED_RUN,
        PM_VERY_LOW_POWER_RUN,
        PM_WAIT,
        PM_VERY_LOW_POWER_WAIT,
        PM_STOP,
        PM_VERY_LOW_POWER_STOP,
        PM_LOW_LEAK_STOP,
        PM_UPPER_LEAK_STOP_LEVEL,
        PM_MIDDLE_LEAK_STOP_LEVEL,
        PM_DEEPEST_LEAK_STOP_LEVEL
    } power_mode_t;

    // Per-mode retention and gating controls to the power fabric
    typedef struct packed {
        logic reduced_clock;
        logic low_voltage_detect_on;
        logic nested_irq_ctrl_on;
        logic async_wake_irq_ctrl_on;
        logic periph_clock_gate;
        logic periph_freeze;
        logic periph_power_off;
        logic sram_retain;
        logic reg_file_retain;
        logic outputs_hold;
        logic por_detect_on;
        logic core_sleep;
    } power_ctrl_t;

    // Run-mode controls: detector, nested controller, SRAM, register file and POR detect on
    localparam power_ctrl_t RUN_CTRL_RESET = 12'h61A;

    // Sleep entry request from the core
    typedef struct packed {
        logic wait_for_irq;
        logic wait_for_event;
        logic deep_sleep;
    } sleep_req_t;

endpackage : power_wake_pkg

// ### hdl/low_power_mode_wakeup_control.sv
// Power-mode sequencer with low-leakage wake unit and register port
// Functional notes
// - Wake unit active in leakage stops and until level-exit ack; a nonzero ack written in the entry cycle switches it off for that stop
// - Exit from low-leak stop disables unit
// - After deep-level exit detect until acknowledged
// - 32 pin inputs, 8 module inputs
// - Module inputs 0,1,4,5,7 used; others reserved
// - USB data pins wake only in host
// - Module wake needs enable, peripheral, interrupt
// - Module flags cleared only by peripheral
// - Sleep instruction enters wait or stop
// - Wake path chosen per mode
// - Low-power run/wait reduce clock, detector off
// - Stop retains all, detector on, async wake
// - Very-low-power stop retains SRAM, detector off
// - Low-leak stop retains SRAM, file; outputs held
// - Leakage levels power off peripherals, unit runs
// - Upper level keeps SRAM; middle only file
// - Deepest level keeps file; POR detect selectable
`timescale 1ns/100ps
`default_nettype none
module low_power_mode_wakeup_control
    import power_wake_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    input  wire sleep_req_t  sleep_req,
    input  wire logic        core_irq_pending,
    input  wire logic [31:0] wake_pin_input,
    input  wire logic [7:0]  wake_module_flag,
    input  wire logic [7:0]  module_source_enabled,
    input  wire logic        usb_host_mode,
    output power_mode_t      power_mode,
    output power_ctrl_t      power_ctrl,
    output logic             low_leak_wake_unit_active,
    output logic             wake_request,
    output logic             irq
);

    typedef struct packed {
        logic [31:0] pin_sync1;
        logic [31:0] pin_sync2;
        logic [7:0]  mod_sync1;
        logic [7:0]  mod_sync2;
        logic        usb_sync1;
        logic        usb_sync2;
        logic [5:0]  mode_ctrl;
        logic [31:0] pin_enable;
        logic [7:0]  module_wake_enable;
        logic [31:0] pin_flags;
        logic        unit_on;
        logic        await_ack;
        power_mode_t mode;
        power_ctrl_t ctrl;
        logic        wake_req;
        logic [1:0]  irq_status;
        logic [1:0]  irq_enable;
        logic        irq_out;
        logic [31:0] rdata;
    } state_t;

    state_t cur;
    state_t next_cur;

    // Retention and gating set per mode
    function automatic power_ctrl_t mode_controls(input power_mode_t m, input logic por_sel);
        power_ctrl_t c;
        c = '0;
        c.low_voltage_detect_on = 1'b1;
        c.nested_irq_ctrl_on    = 1'b1;
        c.sram_retain           = 1'b1;
        c.reg_file_retain       = 1'b1;
        c.por_detect_on         = 1'b1;
        unique case (m)
            PM_RUN, PM_HIGH_SPEED_RUN: begin
            end
            PM_WAIT: begin
                c.core_sleep = 1'b1;
            end
            PM_VERY_LOW_POWER_RUN, PM_VERY_LOW_POWER_WAIT: begin
                c.reduced_clock         = 1'b1;
                c.low_voltage_detect_on = 1'b0;
                c.core_sleep            = (m == PM_VERY_LOW_POWER_WAIT);
            end
            PM_STOP: begin
                c.core_sleep             = 1'b1;
                c.periph_clock_gate      = 1'b1;
                c.nested_irq_ctrl_on     = 1'b0;
                c.async_wake_irq_ctrl_on = 1'b1;
            end
            PM_VERY_LOW_POWER_STOP: begin
                c.core_sleep             = 1'b1;
                c.periph_clock_gate      = 1'b1;
                c.low_voltage_detect_on  = 1'b0;
                c.nested_irq_ctrl_on     = 1'b0;
                c.async_wake_irq_ctrl_on = 1'b1;
            end
            PM_LOW_LEAK_STOP: begin
                c.core_sleep         = 1'b1;
                c.nested_irq_ctrl_on = 1'b0;
                c.periph_freeze      = 1'b1;
                c.outputs_hold       = 1'b1;
            end
            PM_UPPER_LEAK_STOP_LEVEL, PM_MIDDLE_LEAK_STOP_LEVEL, PM_DEEPEST_LEAK_STOP_LEVEL: begin
                c.core_sleep         = 1'b1;
                c.nested_irq_ctrl_on = 1'b0;
                c.periph_power_off   = 1'b1;
                c.outputs_hold       = 1'b1;
                c.sram_retain        = (m == PM_UPPER_LEAK_STOP_LEVEL);
                c.por_detect_on      = (m != PM_DEEPEST_LEAK_STOP_LEVEL) | por_sel;
            end
        endcase
        return c;
    endfunction : mode_controls

    function automatic logic is_leak_stop(input power_mode_t m);
        return (m == PM_LOW_LEAK_STOP) || (m == PM_UPPER_LEAK_STOP_LEVEL) ||
               (m == PM_MIDDLE_LEAK_STOP_LEVEL) || (m == PM_DEEPEST_LEAK_STOP_LEVEL);
    endfunction : is_leak_stop

    logic        wr_hit;
    logic [31:0] pin_mask;
    logic [31:0] pin_hits;
    logic [7:0]  mod_hits;
    logic        any_wake;
    logic [1:0]  irq_set;
    power_mode_t target;

    always_comb begin
        next_cur = cur;
        irq_set  = 2'b00;
        target   = PM_STOP;
        wr_hit   = reg_write;

        next_cur.pin_sync1 = wake_pin_input;
        next_cur.pin_sync2 = cur.pin_sync1;
        next_cur.mod_sync1 = wake_module_flag;
        next_cur.mod_sync2 = cur.mod_sync1;
        next_cur.usb_sync1 = usb_host_mode;
        next_cur.usb_sync2 = cur.usb_sync1;

        // Reserved pins never wake; USB data pins only count in host role
        pin_mask = cur.pin_enable & PIN_PRESENT_MASK;
        if (!cur.usb_sync2) begin
            pin_mask[PIN_USB_DP] = 1'b0;
            pin_mask[PIN_USB_DM] = 1'b0;
        end
        pin_hits = cur.pin_sync2 & pin_mask;
        // Peripheral and its interrupt enable are folded into module_source_enabled
        mod_hits = cur.mod_sync2 & cur.module_wake_enable & module_source_enabled
                   & MODULE_PRESENT_MASK;
        any_wake = cur.unit_on && ((|pin_hits) || (|mod_hits));

        // Pin flags are ours and sticky; module flags are only observed
        if (cur.unit_on) begin
            next_cur.pin_flags = cur.pin_flags | pin_hits;
        end

        next_cur.wake_req = 1'b0;
        unique case (cur.mode)
            PM_RUN, PM_HIGH_SPEED_RUN, PM_VERY_LOW_POWER_RUN: begin
                if (sleep_req.wait_for_irq || sleep_req.wait_for_event) begin
                    if (!sleep_req.deep_sleep) begin
                        next_cur.mode = (cur.mode == PM_VERY_LOW_POWER_RUN) ? PM_VERY_LOW_POWER_WAIT : PM_WAIT;
                    end else begin
                        unique case (stop_cfg_t'(cur.mode_ctrl[CTRL_STOP_LSB +: 3]))
                            STOP_VERY_LOW_POWER: target = PM_VERY_LOW_POWER_STOP;
                            STOP_LOW_LEAK:       target = PM_LOW_LEAK_STOP;
                            STOP_UPPER_LEVEL:    target = PM_UPPER_LEAK_STOP_LEVEL;
                            STOP_MIDDLE_LEVEL:   target = PM_MIDDLE_LEAK_STOP_LEVEL;
                            STOP_DEEPEST_LEVEL:  target = PM_DEEPEST_LEAK_STOP_LEVEL;
                            default:             target = PM_STOP;
                        endcase
                        next_cur.mode = target;
                        if (is_leak_stop(target)) begin
                            next_cur.unit_on   = 1'b1;
                            next_cur.pin_flags = '0;
                        end
                    end
                    irq_set[IRQ_ENTER_BIT] = 1'b1;
                end else begin
                    unique case (run_cfg_t'(cur.mode_ctrl[CTRL_RUN_LSB +: 2]))
                        RUN_HIGH_SPEED:     next_cur.mode = PM_HIGH_SPEED_RUN;
                        RUN_VERY_LOW_POWER: next_cur.mode = PM_VERY_LOW_POWER_RUN;
                        default:            next_cur.mode = PM_RUN;
                    endcase
                end
            end
            PM_WAIT, PM_STOP: begin
                // Nested controller in wait, async controller in stop
                if (core_irq_pending) begin
                    next_cur.mode = PM_RUN;
                end
            end
            PM_VERY_LOW_POWER_WAIT, PM_VERY_LOW_POWER_STOP: begin
                if (core_irq_pending) begin
                    next_cur.mode = PM_VERY_LOW_POWER_RUN;
                end
            end
            PM_LOW_LEAK_STOP, PM_UPPER_LEAK_STOP_LEVEL, PM_MIDDLE_LEAK_STOP_LEVEL,
            PM_DEEPEST_LEAK_STOP_LEVEL: begin
                if (any_wake) begin
                    next_cur.wake_req = 1'b1;
                    next_cur.mode     = PM_RUN;
                    irq_set[IRQ_WAKE_BIT] = 1'b1;
                    if (cur.mode == PM_LOW_LEAK_STOP) begin
                        next_cur.unit_on = 1'b0;
                    end else begin
                        next_cur.await_ack = 1'b1;
                    end
                end
            end
            default: next_cur.mode = PM_RUN;
        endcase
        // Outside leakage stops the unit stays off unless awaiting acknowledgement
        if (!is_leak_stop(next_cur.mode) && !next_cur.await_ack) begin
            next_cur.unit_on = 1'b0;
        end

        next_cur.ctrl = mode_controls(next_cur.mode, cur.mode_ctrl[CTRL_POR_BIT]);

        if (wr_hit) begin
            unique case (reg_addr)
                REG_MODE_CTRL:  next_cur.mode_ctrl = reg_wdata[5:0];
                REG_PIN_ENABLE: next_cur.pin_enable = reg_wdata;
                REG_MOD_ENABLE: next_cur.module_wake_enable = reg_wdata[7:0];
                REG_WAKE_ACK: begin
                    // A nonzero acknowledge outside a leakage stop ends detection; a new pin hit in the same cycle stays set
                    next_cur.pin_flags = (cur.pin_flags & ~reg_wdata) | (cur.unit_on ? pin_hits : 32'h0);
                    if (reg_wdata == 32'h0) begin
                    end else if (!is_leak_stop(cur.mode)) begin
                        next_cur.await_ack = 1'b0;
                        next_cur.unit_on   = 1'b0;
                    end
                end
                REG_IRQ_ENABLE: next_cur.irq_enable = reg_wdata[1:0];
                REG_IRQ_CLEAR:  next_cur.irq_status = cur.irq_status & ~reg_wdata[1:0];
                default: begin
                end
            endcase
        end
        next_cur.irq_status = next_cur.irq_status | irq_set;
        next_cur.irq_out    = |(next_cur.irq_status & next_cur.irq_enable);

        next_cur.rdata = 32'h0;
        if (reg_read) begin
            unique case (reg_addr)
                REG_MODE_CTRL:  next_cur.rdata = {26'h0, cur.mode_ctrl};
                REG_MODE_STAT:  next_cur.rdata = {26'h0, cur.await_ack, cur.unit_on, cur.mode};
                REG_PIN_ENABLE: next_cur.rdata = cur.pin_enable;
                REG_MOD_ENABLE: next_cur.rdata = {24'h0, cur.module_wake_enable};
                REG_PIN_FLAGS:  next_cur.rdata = cur.pin_flags;
                REG_IRQ_STATUS: next_cur.rdata = {30'h0, cur.irq_status};
                REG_IRQ_ENABLE: next_cur.rdata = {30'h0, cur.irq_enable};
                REG_MOD_FLAGS:  next_cur.rdata = {24'h0, cur.mod_sync2 & MODULE_PRESENT_MASK};
                default:        next_cur.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur            <= '0;
            cur.mode_ctrl  <= MODE_CTRL_RESET;
            cur.pin_enable <= PIN_ENABLE_RESET;
            cur.module_wake_enable <= MOD_ENABLE_RESET;
            cur.mode       <= PM_RUN;
            cur.ctrl       <= RUN_CTRL_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata                 = cur.rdata;
    assign power_mode                = cur.mode;
    assign power_ctrl                = cur.ctrl;
    assign low_leak_wake_unit_active = cur.unit_on;
    assign wake_request              = cur.wake_req;
    assign irq                       = cur.irq_out;

endmodule : low_power_mode_wakeup_control
`default_nettype wire

// ### verification/power_wake_props.sv
// Concurrent checks on the power-mode and wake ports
`timescale 1ns/100ps
`default_nettype none
module power_wake_props
    import power_wake_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire sleep_req_t  sleep_req,
    input wire power_mode_t power_mode,
    input wire power_ctrl_t power_ctrl,
    input wire logic        low_leak_wake_unit_active,
    input wire logic        wake_request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    function automatic logic leak(power_mode_t m);
        return m inside {PM_LOW_LEAK_STOP, PM_UPPER_LEAK_STOP_LEVEL, PM_MIDDLE_LEAK_STOP_LEVEL,
                         PM_DEEPEST_LEAK_STOP_LEVEL};
    endfunction : leak

    sequence s_lls_exit;
        power_mode == PM_LOW_LEAK_STOP ##1 power_mode == PM_RUN;
    endsequence
    sequence s_level_exit;
        leak(power_mode) && power_mode != PM_LOW_LEAK_STOP ##1 power_mode == PM_RUN;
    endsequence

    chk_unit_rise_leak: assert property ($rose(low_leak_wake_unit_active) |-> leak(power_mode))
        else $error("wake unit rose outside a leakage stop");
    chk_lls_exit_off: assert property (s_lls_exit |-> !low_leak_wake_unit_active)
        else $error("wake unit still on after low-leak exit");
    chk_level_exit_on: assert property (s_level_exit |-> low_leak_wake_unit_active)
        else $error("wake unit off before acknowledge");
    chk_leak_exit_req: assert property (leak($past(power_mode)) && !leak(power_mode) |-> wake_request)
        else $error("leakage stop left without wake request");
    chk_wake_pulse: assert property (wake_request |-> power_mode == PM_RUN ##1 !wake_request)
        else $error("wake request not a one-cycle pulse into run");
    chk_wait_entry: assert property (power_mode == PM_RUN && (sleep_req.wait_for_irq || sleep_req.wait_for_event)
        && !sleep_req.deep_sleep |=> power_mode == PM_WAIT)
        else $error("sleep request did not enter wait");
    chk_vlp_clock: assert property (power_mode inside {PM_VERY_LOW_POWER_RUN, PM_VERY_LOW_POWER_WAIT}
        |-> power_ctrl.reduced_clock && !power_ctrl.low_voltage_detect_on)
        else $error("low-power run or wait controls wrong");
    chk_stop_ctrl: assert property (power_mode == PM_STOP |-> power_ctrl.low_voltage_detect_on
        && !power_ctrl.nested_irq_ctrl_on && power_ctrl.async_wake_irq_ctrl_on && power_ctrl.sram_retain)
        else $error("stop controls wrong");
    chk_very_low_power_stop_ctrl: assert property (power_mode == PM_VERY_LOW_POWER_STOP |-> power_ctrl.sram_retain
        && !power_ctrl.low_voltage_detect_on && !power_ctrl.nested_irq_ctrl_on)
        else $error("very-low-power stop controls wrong");
    chk_lls_ctrl: assert property (power_mode == PM_LOW_LEAK_STOP |-> power_ctrl.sram_retain
        && power_ctrl.reg_file_retain && power_ctrl.outputs_hold)
        else $error("low-leak stop controls wrong");
    chk_level_ctrl: assert property (leak(power_mode) && power_mode != PM_LOW_LEAK_STOP
        |-> power_ctrl.periph_power_off && power_ctrl.reg_file_retain
        && power_ctrl.sram_retain == (power_mode == PM_UPPER_LEAK_STOP_LEVEL))
        else $error("leakage level controls wrong");
endmodule : power_wake_props

bind low_power_mode_wakeup_control power_wake_props u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .sleep_req(sleep_req), .power_mode(power_mode),
    .power_ctrl(power_ctrl), .low_leak_wake_unit_active(low_leak_wake_unit_active), .wake_request(wake_request)
);
`default_nettype wire

// ### verification/core_wake_model.sv
// Behavioural core and module wake-source model
`timescale 1ns/100ps
`default_nettype none
module core_wake_model
    import power_wake_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        sleep_go,
    input  wire logic        sleep_deep,
    input  wire logic        irq_go,
    input  wire logic [7:0]  flag_set,
    input  wire logic [7:0]  flag_clr,
    input  wire power_mode_t power_mode,
    output sleep_req_t       sleep_req,
    output logic             core_irq_pending,
    output logic [7:0]       wake_module_flag
);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sleep_req <= '0;
            core_irq_pending <= 1'b0;
            wake_module_flag <= 8'h00;
        end else begin
            // The instruction executes once, so the request lasts one cycle
            sleep_req <= '{wait_for_irq: sleep_go, wait_for_event: 1'b0, deep_sleep: sleep_go & sleep_deep};
            // Held until the core runs again and services it
            if (irq_go)
                core_irq_pending <= 1'b1;
            else if (power_mode inside {PM_RUN, PM_VERY_LOW_POWER_RUN})
                core_irq_pending <= 1'b0;
            wake_module_flag <= (wake_module_flag | flag_set) & ~flag_clr;
        end
    end
endmodule : core_wake_model
`default_nettype wire

// ### verification/low_power_mode_wakeup_control_tb.sv
// Self-checking bench for the power-mode sequencer and wake unit
`timescale 1ns/100ps
`default_nettype none
module low_power_mode_wakeup_control_tb
    import power_wake_pkg::*;
;
    typedef struct packed {
        logic        deep;
        logic [2:0]  cfg;
        power_mode_t mode;
        logic [2:0]  keep;
    } row_t;
    // keep = sram, register file, wake unit
    row_t rows [7] = '{'{1'b0, 3'h0, PM_WAIT, 3'b110}, '{1'b1, 3'h0, PM_STOP, 3'b110},
        '{1'b1, 3'h1, PM_VERY_LOW_POWER_STOP, 3'b110}, '{1'b1, 3'h2, PM_LOW_LEAK_STOP, 3'b111},
        '{1'b1, 3'h3, PM_UPPER_LEAK_STOP_LEVEL, 3'b111}, '{1'b1, 3'h4, PM_MIDDLE_LEAK_STOP_LEVEL, 3'b011},
        '{1'b1, 3'h5, PM_DEEPEST_LEAK_STOP_LEVEL, 3'b011}};
    logic        clk_sys = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, usb_host = 1'b0;
    logic        sleep_go = 1'b0, sleep_deep = 1'b0, irq_go = 1'b0, core_irq_pending, unit_on, wake_req, irq;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, pins = 32'h0, reg_rdata, v;
    logic [7:0]  mflag, src_en = 8'hFE, fset = 8'h00, fclr = 8'h00;
    sleep_req_t  sleep_req;
    power_mode_t power_mode;
    power_ctrl_t power_ctrl;
    int          errors = 0, n_compared = 0, cycles = 0;

    low_power_mode_wakeup_control uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sleep_req(sleep_req), .core_irq_pending(core_irq_pending), .wake_pin_input(pins),
        .wake_module_flag(mflag), .module_source_enabled(src_en), .usb_host_mode(usb_host),
        .power_mode(power_mode), .power_ctrl(power_ctrl), .low_leak_wake_unit_active(unit_on),
        .wake_request(wake_req), .irq(irq));
    core_wake_model u_core (.clk_sys(clk_sys), .rst_n(rst_n), .sleep_go(sleep_go), .sleep_deep(sleep_deep),
        .irq_go(irq_go), .flag_set(fset), .flag_clr(fclr), .power_mode(power_mode), .sleep_req(sleep_req),
        .core_irq_pending(core_irq_pending), .wake_module_flag(mflag));

    initial forever #2 clk_sys = ~clk_sys;

    task automatic close_out();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    // The whole run takes a few hundred cycles; this only cuts a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk_sys);
    endtask : rd
    task automatic wait_mode(input power_mode_t m);
        for (int k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            #1;
            if (power_mode === m)
                break;
        end
        chk("power_mode", 32'(power_mode), 32'(m));
        @(posedge clk_sys);
    endtask : wait_mode
    task automatic go_sleep(input logic deep);
        sleep_go <= 1'b1;
        sleep_deep <= deep;
        @(posedge clk_sys);
        sleep_go <= 1'b0;
    endtask : go_sleep
    task automatic wake_irq();
        irq_go <= 1'b1;
        @(posedge clk_sys);
        irq_go <= 1'b0;
    endtask : wake_irq
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk("reset_out", {14'h0, irq, unit_on, power_mode, power_ctrl}, {14'h0, 2'b00, PM_RUN, 12'h61A});
        rst_n <= 1'b1;
        @(posedge clk_sys);
    endtask : do_reset

    initial begin
        do_reset();
        rd(REG_MOD_ENABLE);
        chk("mod_enable_rst", v, 32'h0);
        rd(4'hF);
        chk("unmapped", v, 32'h0);
        wr(REG_PIN_ENABLE, 32'h1);
        wr(REG_IRQ_ENABLE, 32'h1);
        rd(REG_PIN_ENABLE);
        chk("pin_enable", v, 32'h1);
        for (int i = 0; i < 7; i++) begin
            // POR detect left unselected, so an enable stuck on in the deepest level shows up
            wr(REG_MODE_CTRL, {26'h0, 1'b0, rows[i].cfg, 2'h0});
            go_sleep(rows[i].deep);
            wait_mode(rows[i].mode);
            chk("retain", {29'h0, power_ctrl.sram_retain, power_ctrl.reg_file_retain, unit_on}, 32'(rows[i].keep));
            if (rows[i].cfg == 3'h5)
                chk("por_sel", {31'h0, power_ctrl.por_detect_on}, 32'h0);
            if (rows[i].keep[0])
                pins <= 32'h1;
            else
                wake_irq();
            wait_mode(PM_RUN);
            pins <= 32'h0;
            rd(REG_MODE_STAT);
            chk("await_ack", {30'h0, v[5:4]}, {30'h0, {2{rows[i].cfg > 3'h2}}});
            wr(REG_WAKE_ACK, 32'hFFFF_FFFF);
            rd(REG_MODE_STAT);
            chk("acked", v, 32'h0);
        end
        chk("irq_on", {31'h0, irq}, 32'h1);
        rd(REG_IRQ_STATUS);
        chk("irq_status", v, 32'h3);
        wr(REG_IRQ_CLEAR, 32'h3);
        wr(REG_IRQ_ENABLE, 32'h0);
        rd(REG_IRQ_STATUS);
        chk("irq_cleared", {v[30:0], irq}, 32'h0);
        wr(REG_PIN_ENABLE, 32'h1808_0000);
        // The last row left the deepest level selected; the pin and module cases need low-leak stop
        wr(REG_MODE_CTRL, 32'h8);
        go_sleep(1'b1);
        wait_mode(PM_LOW_LEAK_STOP);
        pins <= 32'h1808_0000;
        repeat (10) @(posedge clk_sys);
        chk("usb_gated", 32'(power_mode), 32'(PM_LOW_LEAK_STOP));
        usb_host <= 1'b1;
        wait_mode(PM_RUN);
        pins <= 32'h0;
        rd(REG_PIN_FLAGS);
        chk("usb_flag", {30'h0, v[27], irq}, 32'h2);
        wr(REG_WAKE_ACK, 32'hFFFF_FFFF);
        wr(REG_MOD_ENABLE, 32'h5);
        go_sleep(1'b1);
        wait_mode(PM_LOW_LEAK_STOP);
        fset <= 8'h05;
        repeat (10) @(posedge clk_sys);
        fset <= 8'h00;
        chk("mod_gated", 32'(power_mode), 32'(PM_LOW_LEAK_STOP));
        src_en <= 8'hFF;
        wait_mode(PM_RUN);
        rd(REG_MOD_FLAGS);
        chk("mod_flag_kept", {31'h0, v[0]}, 32'h1);
        fclr <= 8'hFF;
        wr(REG_MODE_CTRL, 32'h2);
        fclr <= 8'h00;
        wait_mode(PM_VERY_LOW_POWER_RUN);
        go_sleep(1'b0);
        wait_mode(PM_VERY_LOW_POWER_WAIT);
        chk("vlp_ctrl", {29'h0, power_ctrl.reduced_clock, power_ctrl.low_voltage_detect_on, unit_on}, 32'h4);
        wake_irq();
        wait_mode(PM_VERY_LOW_POWER_RUN);
        do_reset();
        rd(REG_PIN_ENABLE);
        chk("pin_enable_rst", v, 32'h0);
        close_out();
    end
endmodule : low_power_mode_wakeup_control_tb
`default_nettype wire
